// *** core/usb_device_dma_setup.v ***
// device dma configuration, counter and request control
`include "dma_setup_defs.vh"
module usb_device_dma_setup
(
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_bus_reset,
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_code,
  input wire i_wr_valid,
  input wire [15:0] i_wr_data,
  input wire i_rd_strobe,
  output reg [15:0] o_rd_data,
  input wire i_transfer_end_polarity,
  input wire i_transfer_end_signal,
  input wire i_dma_ack,
  input wire i_dma_ack_word,
  input wire i_buffer_ready,
  input wire i_endpoint_is_out,
  input wire i_short_packet,
  output wire o_dma_req,
  output reg [3:0] o_dma_endpoint_select,
  output reg [3:0] o_dma_word_index,
  output reg o_send_partial,
  output reg o_transfer_end
);
  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // ------------------------------------------------------------------
  // command phase decode
  // ------------------------------------------------------------------
  localparam PH_IDLE = 2'h0;
  localparam PH_CFG = 2'h1;
  localparam PH_CNT = 2'h2;
  reg [1:0] phase_reg;
  reg [1:0] phase_next;
  reg phase_read_reg;
  reg phase_read_next;
  wire cfg_wr;
  wire cnt_wr;
  wire data_done;

  // each configuration or counter command carries exactly one data word; any other code returns to idle and takes none
  assign data_done = (phase_read_reg ? i_rd_strobe : i_wr_valid) && !i_cmd_valid;
  // a new command in the same cycle wins over a stray data word
  assign cfg_wr = (phase_reg == PH_CFG) && !phase_read_reg && i_wr_valid
    && !i_cmd_valid;
  assign cnt_wr = (phase_reg == PH_CNT) && !phase_read_reg && i_wr_valid
    && !i_cmd_valid;

  // next command phase
  always @*
  begin
    phase_next = phase_reg;
    phase_read_next = phase_read_reg;
    if (i_cmd_valid)
    begin
      phase_read_next = 1'b0;
      case (i_cmd_code)
        `CMD_CFG_WR: phase_next = PH_CFG;
        `CMD_CFG_RD:
        begin
          phase_next = PH_CFG;
          phase_read_next = 1'b1;
        end
        `CMD_CNT_WR: phase_next = PH_CNT;
        `CMD_CNT_RD:
        begin
          phase_next = PH_CNT;
          phase_read_next = 1'b1;
        end
        default: phase_next = PH_IDLE;
      endcase
    end
    else
    begin
      case (phase_reg)
        PH_CFG: if (data_done) phase_next = PH_IDLE;
        PH_CNT: if (data_done) phase_next = PH_IDLE;
        default: phase_next = PH_IDLE;
      endcase
    end
  end

  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= PH_IDLE;
      phase_read_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      phase_read_reg <= phase_read_next;
    end
  end

  // ------------------------------------------------------------------
  // configuration and counter registers
  // ------------------------------------------------------------------
  reg [15:0] cfg_reg;
  reg [15:0] count_reg;
  reg width_flag_reg;
  reg run_reg;
  wire [15:0] remaining;
  wire count_zero;
  wire end_pin;
  wire end_event;
  wire start;
  wire access;
  wire [15:0] cfg_view;

  // external end pin seen active at the level set by i_transfer_end_polarity
  assign end_pin = (i_transfer_end_signal == i_transfer_end_polarity);
  assign start = cfg_wr && i_wr_data[`CFG_RUN] && !run_reg;
  assign access = run_reg && i_dma_ack && !count_zero;

  // transfer ends on pin, counter expiry or short out packet
  assign end_event = run_reg && (end_pin ||
    (cfg_reg[`CFG_CNT_END] && count_zero) ||
    (cfg_reg[`CFG_SHORT] && i_endpoint_is_out && i_short_packet));

  // stored fields; the run bit lives in run_reg
  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg <= `CFG_RESET;
      count_reg <= `CNT_RESET;
    end
    else
    begin
      if (cfg_wr)
        cfg_reg <= i_wr_data & `CFG_WR_MASK;
      if (cnt_wr)
        count_reg <= i_wr_data;
    end
  end

  // dma run state, cleared by bus reset, stop write or end event
  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      run_reg <= 1'b0;
    else if (i_bus_reset)
      run_reg <= 1'b0;
    else if (cfg_wr)
      run_reg <= i_wr_data[`CFG_RUN];
    else if (end_event)
      run_reg <= 1'b0;
  end

  // width of the last access moved
  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      width_flag_reg <= 1'b0;
    else if (access)
      width_flag_reg <= i_dma_ack_word && (remaining > 16'h0001);
  end

  dma_byte_counter u_counter
  (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_load(start),
    .i_load_value(count_reg),
    .i_step(access),
    .i_step_word(i_dma_ack_word),
    .o_remaining(remaining),
    .o_zero(count_zero)
  );

  // ------------------------------------------------------------------
  // data path towards the endpoint buffers
  // ------------------------------------------------------------------
  assign o_dma_req = run_reg && i_buffer_ready && !count_zero;

  // endpoint select, word pointer and end flags
  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_dma_endpoint_select <= 4'h0;
      o_dma_word_index <= 4'h0;
      o_send_partial <= 1'b0;
      o_transfer_end <= 1'b0;
    end
    else
    begin
      o_dma_endpoint_select <= cfg_reg[`CFG_EP_HI:`CFG_EP_LO];
      if (start)
        o_dma_word_index <= `FIRST_DATA_WORD;
      else if (access)
        o_dma_word_index <= o_dma_word_index + 4'h1;
      o_send_partial <= end_event && end_pin && !i_endpoint_is_out;
      o_transfer_end <= end_event;
    end
  end

  // ------------------------------------------------------------------
  // read back
  // ------------------------------------------------------------------
  // burst field 1..0 is only stored and read back through cfg_view; no port carries it to the dma controller
  assign cfg_view = {cfg_reg[15:9], width_flag_reg, cfg_reg[7:4], run_reg, 1'b0,
    cfg_reg[1:0]};

  // read data captured as the command is taken
  always @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_rd_data <= 16'h0000;
    else if (i_cmd_valid && i_cmd_code == `CMD_CFG_RD)
      o_rd_data <= cfg_view;
    else if (i_cmd_valid && i_cmd_code == `CMD_CNT_RD)
      o_rd_data <= remaining;
  end
endmodule

// *** core/dma_setup_defs.vh ***
// constants for the device dma setup block
`ifndef DMA_SETUP_DEFS_VH
`define DMA_SETUP_DEFS_VH
`define CMD_CFG_WR 8'hF0
`define CMD_CFG_RD 8'hF1
`define CMD_CNT_WR 8'hF2
`define CMD_CNT_RD 8'hF3
`define CFG_CNT_END 15
`define CFG_SHORT 14
`define CFG_WIDTH_FLAG 8
`define CFG_EP_HI 7
`define CFG_EP_LO 4
`define CFG_RUN 3
`define CFG_BURST_HI 1
`define CFG_BURST_LO 0
`define CFG_WR_MASK 16'hFEFB
`define CFG_RESET 16'h0000
`define CNT_RESET 16'h0000
`define BURST_1 2'h0
`define BURST_4 2'h1
`define BURST_8 2'h2
`define FIRST_DATA_WORD 4'h1
`endif

// *** core/dma_byte_counter.v ***
// working byte counter of the dma engine
`include "dma_setup_defs.vh"
module dma_byte_counter
(
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_load,
  input wire [15:0] i_load_value,
  input wire i_step,
  input wire i_step_word,
  output reg [15:0] o_remaining,
  output wire o_zero
);
  // bytes moved by one access, never more than what is left
  function [15:0] step_size;
    input word;
    input [15:0] left;
    begin
      if (word && left > 16'h0001)
        step_size = 16'h0002;
      else if (left != 16'h0000)
        step_size = 16'h0001;
      else
        step_size = 16'h0000;
    end
  endfunction

  assign o_zero = (o_remaining == 16'h0000);

  // reload has priority over a decrement in the same cycle
  always @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_remaining <= `CNT_RESET;
    else if (i_load)
      o_remaining <= i_load_value;
    else if (i_step)
      o_remaining <= o_remaining - step_size(i_step_word, o_remaining);
  end
endmodule

// *** testbench/dma_setup_chk.sv ***
// port assertions for the device dma setup block
module dma_setup_chk
(
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_bus_reset,
  input wire i_wr_valid,
  input wire i_dma_ack,
  input wire i_buffer_ready,
  input wire i_endpoint_is_out,
  input wire i_transfer_end_polarity,
  input wire i_transfer_end_signal,
  input wire o_dma_req,
  input wire [3:0] o_dma_endpoint_select,
  input wire [3:0] o_dma_word_index,
  input wire o_send_partial,
  input wire o_transfer_end
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // requests only while the buffer can serve
  a_req_needs_ready: assert property (o_dma_req |-> i_buffer_ready)
    else $error("request without ready buffer");
  a_bus_reset_stops: assert property (i_bus_reset |-> ##2 !o_dma_req)
    else $error("request survives bus reset");
  a_end_stops_req: assert property (o_transfer_end |-> ##2 !o_dma_req)
    else $error("request after transfer end");
  a_pin_ends: assert property ((i_transfer_end_signal == i_transfer_end_polarity) && o_dma_req
    |-> ##[1:3] o_transfer_end)
    else $error("end pin ignored");
  a_partial_in_only: assert property (o_send_partial |-> !i_endpoint_is_out)
    else $error("partial send on out endpoint");
  a_ep_write_only: assert property ($changed(o_dma_endpoint_select)
    |-> $past(i_wr_valid) || $past(i_wr_valid, 2) || $past(i_wr_valid, 3))
    else $error("endpoint select moved without write");
  a_index_moves: assert property ($changed(o_dma_word_index)
    |-> o_dma_word_index == 4'h1 || $past(i_dma_ack) || $past(i_dma_ack, 2))
    else $error("word index moved without access");
  a_req_on_start: assert property ($rose(o_dma_req) && $stable(i_buffer_ready)
    |-> $past(i_wr_valid) || $past(i_wr_valid, 2))
    else $error("request rose without enable write");
endmodule
bind usb_device_dma_setup dma_setup_chk u_dma_setup_chk (.*);

// *** testbench/dma_ctl_model.sv ***
// external dma controller answering the request line
module dma_ctl_model
(
  input wire i_mclk,
  input wire i_req,
  input wire i_word,
  input wire [1:0] i_lat,
  output logic o_ack,
  output wire o_ack_word
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt = 0;
  initial o_ack = 1'b0;
  // one access per request after a chosen wait, with a gap between accesses
  always @(negedge i_mclk)
  begin
    o_ack <= i_req && !o_ack && wait_cnt >= i_lat;
    wait_cnt <= (i_req && !o_ack && wait_cnt < i_lat) ? wait_cnt + 1 : 0;
  end
  // width line shows the inverse outside an access
  assign o_ack_word = o_ack ~^ i_word;
endmodule

// *** testbench/usb_device_dma_setup_tb.sv ***
// self-checking bench for the device dma setup block
module usb_device_dma_setup_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0, i_rst_b = 1'b0, i_bus_reset = 1'b0, i_cmd_valid = 1'b0;
  logic i_wr_valid = 1'b0, i_rd_strobe = 1'b0, i_transfer_end_polarity = 1'b0;
  logic i_transfer_end_signal = 1'b1, i_buffer_ready = 1'b0, i_endpoint_is_out = 1'b0;
  logic i_short_packet = 1'b0, word_mode = 1'b0, rd_pend = 1'b0, last_flag = 1'b0;
  logic [15:0] fb = 16'h0000;
  logic [7:0] i_cmd_code = 8'h00;
  logic [15:0] i_wr_data = 16'h0000, lfsr = 16'hFCDE, cnt;
  logic [3:0] ep;
  logic [1:0] lat = 2'h0;
  wire [15:0] o_rd_data;
  wire o_dma_req, i_dma_ack, i_dma_ack_word, o_send_partial, o_transfer_end;
  wire [3:0] o_dma_endpoint_select, o_dma_word_index;
  logic [15:0] exp_q[$];
  int err_count = 0, n_tests = 0;
  always #25 i_mclk = ~i_mclk;
  usb_device_dma_setup u_usb_device_dma_setup (.*);
  dma_ctl_model u_dma_ctl_model (.i_mclk(i_mclk), .i_req(o_dma_req), .i_word(word_mode),
    .i_lat(lat), .o_ack(i_dma_ack), .o_ack_word(i_dma_ack_word));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // command phase then one data word, driven on falling edges
  task automatic cmd(input logic [7:0] c, input logic [15:0] d, input logic rd);
    @(negedge i_mclk);
    i_cmd_valid = 1'b1;
    i_cmd_code = c;
    @(negedge i_mclk);
    lfsr = nxt(lfsr);
    i_cmd_valid = 1'b0;
    i_cmd_code = lfsr[7:0];
    i_wr_valid = !rd;
    i_rd_strobe = rd;
    i_wr_data = rd ? lfsr : d;
    @(negedge i_mclk);
    i_wr_valid = 1'b0;
    i_rd_strobe = 1'b0;
    i_wr_data = ~i_wr_data;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    cmd(c, 16'h0000, 1'b1);
  endtask
  task automatic wait_for(input logic partial);
    int n;
    // end pulses are looked at on the falling edge, where they stand settled
    for (n = 0; (partial ? o_send_partial : o_transfer_end) !== 1'b1 && n < 200; n++)
      @(negedge i_mclk);
    check(16'(n < 200), 16'h0001);
    if (n >= 200)
      summarize();
    else
      @(negedge i_mclk);
  endtask
  // read words are compared in issue order one cycle after their command
  always @(posedge i_mclk)
  begin
    if (rd_pend)
      check(o_rd_data, exp_q.pop_front());
    rd_pend <= i_cmd_valid && (i_cmd_code == 8'hF1 || i_cmd_code == 8'hF3);
  end
  initial
  begin
    repeat (4) @(negedge i_mclk);
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_mclk);
    rd(8'hF1, 16'h0000);
    rd(8'hF3, 16'h0000);
    // counter-end transfers over every burst code with random size and width
    for (int b = 0; b < 4; b++)
    begin
      lfsr = nxt(lfsr);
      word_mode = lfsr[0];
      lat = lfsr[2:1];
      cnt = {12'h000, lfsr[6:3]} + 16'h0001;
      ep = lfsr[10:7];
      i_buffer_ready = 1'b1;
      cmd(8'hF2, cnt, 1'b0);
      cmd(8'hF0, {8'h80, ep, 4'h8} | 16'(b), 1'b0);
      wait_for(1'b0);
      check({12'h000, o_dma_endpoint_select}, {12'h000, ep});
      // pointer starts past the length word and moves once per access
      check({12'h000, o_dma_word_index},
        {12'h000, 4'(16'h0001 + (word_mode ? (cnt + 16'h0001) >> 1 : cnt))});
      last_flag = word_mode & ~cnt[0];
      rd(8'hF1, {7'h40, last_flag, ep, 2'b00, b[1:0]});
      rd(8'hF3, 16'h0000);
    end
    // stalled start, read-only bits, bus reset, reload and short packet end
    // the width flag keeps what the last loop transfer left in it
    fb = {7'h00, last_flag, 8'h00};
    i_buffer_ready = 1'b0;
    i_endpoint_is_out = 1'b1;
    cmd(8'hF2, 16'h0028, 1'b0);
    cmd(8'hF0, 16'h415C, 1'b0);
    rd(8'hF1, 16'h4058 | fb);
    rd(8'hF3, 16'h0028);
    cmd(8'hF5, 16'hFFFF, 1'b0);
    i_bus_reset = 1'b1;
    @(negedge i_mclk) i_bus_reset = 1'b0;
    rd(8'hF1, 16'h4050 | fb);
    rd(8'hF3, 16'h0028);
    cmd(8'hF0, 16'h4058, 1'b0);
    i_short_packet = 1'b1;
    @(negedge i_mclk) i_short_packet = 1'b0;
    wait_for(1'b0);
    rd(8'hF1, 16'h4050 | fb);
    // external end on an in endpoint with short mode kept off
    i_endpoint_is_out = 1'b0;
    i_buffer_ready = 1'b1;
    lat = 2'h3;
    i_transfer_end_polarity = lfsr[11];
    i_transfer_end_signal = !lfsr[11];
    cmd(8'hF0, 16'h0018, 1'b0);
    i_transfer_end_signal = lfsr[11];
    wait_for(1'b1);
    i_transfer_end_signal = !lfsr[11];
    // a write with the run bit cleared stops a running transfer
    cmd(8'hF0, 16'h0018, 1'b0);
    cmd(8'hF0, 16'h0010, 1'b0);
    @(negedge i_mclk);
    check({15'h0000, o_dma_req}, 16'h0000);
    rd(8'hF1, 16'h0010 | fb);
    repeat (3) @(negedge i_mclk);
    summarize();
  end
endmodule
